//--- design/cfg_port_interp.v
// Configuration port packet interpreter and reply builder
`timescale 1ns/1ps
`include "cfg_port_consts.vh"

module cfg_port_interp (
    input  wire        mclk_in,                 // 40 MHz clock
    input  wire        rst_b_in,                // Async reset, active low
    input  wire [7:0]  rx_data_in,              // Received UART byte
    input  wire        rx_valid_in,             // Received byte valid
    output reg         rx_ready_out,            // Ready for a byte
    output reg  [7:0]  tx_data_out,             // Byte to send
    output reg         tx_valid_out,            // Send byte valid
    input  wire        tx_ready_in,             // UART takes byte
    input  wire        baud_default_strap_b_in, // Low forces 115200
    input  wire [15:0] nv_address_in,           // Stored address
    input  wire [15:0] nv_net_id_in,            // Stored network ID
    input  wire [7:0]  nv_channel_in,           // Stored channel
    input  wire [7:0]  nv_baud_in,              // Stored baud code
    output reg         nv_write_out,            // Store applied values
    output reg  [15:0] address_out,             // Applied address
    output reg  [15:0] net_id_out,              // Applied network ID
    output reg  [7:0]  channel_out,             // Applied channel
    output reg  [7:0]  baud_code_out,           // Applied baud code
    output reg  [15:0] baud_div_out,            // Effective divisor
    output reg         restart_out,             // Restart pulse
    output reg         lq_req_out,              // Link test pulse
    output reg  [15:0] lq_target_out            // Link test peer
);

    // ======================================================
    // States
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_LEN  = 7'h02;
    localparam [6:0] S_HDR  = 7'h04;
    localparam [6:0] S_PAY  = 7'h08;
    localparam [6:0] S_END  = 7'h10;
    localparam [6:0] S_EXEC = 7'h20;
    localparam [6:0] S_SEND = 7'h40;

    reg [6:0]  state;
    reg        loaded;
    reg [7:0]  len;
    reg [7:0]  cnt;
    reg [7:0]  src_port;
    reg [7:0]  dst_port;
    reg [15:0] dst_addr;
    reg [7:0]  pay [0:2];
    reg [15:0] pend_addr;
    reg [15:0] pend_net_id;
    reg [7:0]  pend_chan;
    reg [7:0]  pend_baud;
    reg [7:0]  rep_src;
    reg [7:0]  rep_dst;
    reg [1:0]  rep_n;
    reg [7:0]  rp [0:2];
    reg [3:0]  tx_idx;
    reg [7:0]  cur_byte;

    wire       take   = rx_valid_in & rx_ready_out;
    wire [7:0] plen   = len - `FRM_HDR_LEN;
    wire [7:0] cmd    = pay[0];
    wire [15:0] val16 = {pay[2], pay[1]};
    wire [3:0] tx_end = {2'b00, rep_n} + 4'h6;
    wire        set_known;
    wire [15:0] act_div;
    wire [7:0]  eff_baud;

    // ======================================================
    // Baud lookups for write check and applied code
    baud_code_map u_set_map (
        .code_in   (pay[1]),
        .div_out   (),
        .known_out (set_known)
    );

    baud_code_map u_act_map (
        .code_in   (eff_baud),
        .div_out   (act_div),
        .known_out ()
    );

    // Strap low overrides the applied code
    assign eff_baud = baud_default_strap_b_in ? baud_code_out : `BAUD_CODE_DFLT;

    // ======================================================
    // Reply byte selection
    always @* begin
        cur_byte = `FRM_END;
        if (tx_idx != tx_end) begin
            case (tx_idx)
                4'h0:    cur_byte = `FRM_START;
                4'h1:    cur_byte = {6'h00, rep_n} + `FRM_HDR_LEN;
                4'h2:    cur_byte = rep_src;
                4'h3:    cur_byte = rep_dst;
                4'h4:    cur_byte = `LOCAL_ADDR_LO;
                4'h5:    cur_byte = `LOCAL_ADDR_HI;
                4'h6:    cur_byte = rp[0];
                4'h7:    cur_byte = rp[1];
                4'h8:    cur_byte = rp[2];
                default: cur_byte = `FRM_END;
            endcase
        end
    end

    // ======================================================
    // Registered divisor for the effective baud code
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            baud_div_out <= 16'h0000;
        end else begin
            baud_div_out <= act_div;
        end
    end

    // ======================================================
    // Frame receive, command execution and reply send
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state         <= S_IDLE;
            loaded        <= 1'b0;
            rx_ready_out  <= 1'b0;
            tx_data_out   <= 8'h00;
            tx_valid_out  <= 1'b0;
            nv_write_out  <= 1'b0;
            address_out   <= 16'h0000;
            net_id_out    <= 16'h0000;
            channel_out   <= 8'h00;
            baud_code_out <= 8'h00;
            restart_out   <= 1'b0;
            lq_req_out    <= 1'b0;
            lq_target_out <= 16'h0000;
            len           <= 8'h00;
            cnt           <= 8'h00;
            src_port      <= 8'h00;
            dst_port      <= 8'h00;
            dst_addr      <= 16'h0000;
            pay[0]        <= 8'h00;
            pay[1]        <= 8'h00;
            pay[2]        <= 8'h00;
            pend_addr     <= 16'h0000;
            pend_net_id   <= 16'h0000;
            pend_chan     <= 8'h00;
            pend_baud     <= 8'h00;
            rep_src       <= 8'h00;
            rep_dst       <= 8'h00;
            rep_n         <= 2'b00;
            rp[0]         <= 8'h00;
            rp[1]         <= 8'h00;
            rp[2]         <= 8'h00;
            tx_idx        <= 4'h0;
        end else begin
            restart_out  <= 1'b0;
            nv_write_out <= 1'b0;
            lq_req_out   <= 1'b0;
            if (!loaded) begin
                // Pick up stored settings after reset release
                loaded        <= 1'b1;
                address_out   <= nv_address_in;
                net_id_out    <= nv_net_id_in;
                channel_out   <= nv_channel_in;
                baud_code_out <= nv_baud_in;
                pend_addr     <= nv_address_in;
                pend_net_id   <= nv_net_id_in;
                pend_chan     <= nv_channel_in;
                pend_baud     <= nv_baud_in;
                rx_ready_out  <= 1'b1;
            end else begin
                case (state)
                    S_IDLE: begin
                        if (take && rx_data_in == `FRM_START) begin
                            state <= S_LEN;
                        end
                    end
                    S_LEN: begin
                        if (take) begin
                            len   <= rx_data_in;
                            cnt   <= 8'h00;
                            state <= (rx_data_in < `FRM_HDR_LEN) ? S_IDLE : S_HDR;
                        end
                    end
                    S_HDR: begin
                        if (take) begin
                            case (cnt[1:0])
                                2'b00:   src_port       <= rx_data_in;
                                2'b01:   dst_port       <= rx_data_in;
                                2'b10:   dst_addr[7:0]  <= rx_data_in;
                                default: dst_addr[15:8] <= rx_data_in;
                            endcase
                            cnt <= cnt + 8'h01;
                            if (cnt == `FRM_HDR_LAST) begin
                                cnt   <= 8'h00;
                                state <= (len == `FRM_HDR_LEN) ? S_END : S_PAY;
                            end
                        end
                    end
                    S_PAY: begin
                        if (take) begin
                            if (cnt < `PAY_MAX) begin
                                pay[cnt[1:0]] <= rx_data_in;
                            end
                            cnt <= cnt + 8'h01;
                            if (cnt == plen - 8'h01) begin
                                state <= S_END;
                            end
                        end
                    end
                    S_END: begin
                        if (take) begin
                            if (rx_data_in == `FRM_END) begin
                                state        <= S_EXEC;
                                rx_ready_out <= 1'b0;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_EXEC: begin
                        // Default: status reply from config port
                        state   <= S_SEND;
                        tx_idx  <= 4'h0;
                        rep_src <= `PORT_CFG;
                        rep_dst <= `PORT_HOST;
                        rep_n   <= 2'b01;
                        rp[0]   <= `ST_OK;
                        if (src_port < `PORT_SRC_MIN) begin
                            rep_src <= `PORT_ERR;
                            rep_dst <= src_port;
                            rep_n   <= 2'b10;
                            rp[0]   <= `ERR_BAD_PORT;
                            rp[1]   <= src_port;
                        end else if (dst_port == `PORT_LQ) begin
                            lq_req_out    <= 1'b1;
                            lq_target_out <= {pay[1], pay[0]};
                            state         <= S_IDLE;
                            rx_ready_out  <= 1'b1;
                        end else if (dst_port != `PORT_CFG) begin
                            rep_src <= `PORT_ERR;
                            rep_dst <= src_port;
                            rep_n   <= 2'b10;
                            rp[0]   <= `ERR_BAD_PORT;
                            rp[1]   <= dst_port;
                        end else if (dst_addr != `LOCAL_ADDR) begin
                            rp[0] <= `ST_REMOTE;
                        end else if (plen == 8'h00) begin
                            rp[0] <= `ST_BAD_LEN;
                        end else begin
                            case (cmd)
                                `CMD_RD_ADDR, `CMD_RD_NETID: begin
                                    if (plen != 8'h01) begin
                                        rp[0] <= `ST_BAD_LEN;
                                    end else if (cmd == `CMD_RD_ADDR) begin
                                        rep_n <= 2'b11;
                                        rp[0] <= `RPL_ADDR;
                                        rp[1] <= pend_addr[7:0];
                                        rp[2] <= pend_addr[15:8];
                                    end else begin
                                        rep_n <= 2'b11;
                                        rp[0] <= `RPL_NETID;
                                        rp[1] <= pend_net_id[7:0];
                                        rp[2] <= pend_net_id[15:8];
                                    end
                                end
                                `CMD_RD_CHAN, `CMD_RD_BAUD: begin
                                    if (plen != 8'h01) begin
                                        rp[0] <= `ST_BAD_LEN;
                                    end else if (cmd == `CMD_RD_CHAN) begin
                                        rep_n <= 2'b10;
                                        rp[0] <= `RPL_CHAN;
                                        rp[1] <= pend_chan;
                                    end else begin
                                        rep_n <= 2'b10;
                                        rp[0] <= `RPL_BAUD;
                                        rp[1] <= pend_baud;
                                    end
                                end
                                `CMD_SET_ADDR: begin
                                    if (plen != 8'h03) begin
                                        rp[0] <= `ST_BAD_LEN;
                                    end else if (val16 == `LOCAL_ADDR ||
                                                 val16 == `ADDR_ALL) begin
                                        rp[0] <= `ST_BAD_VAL;
                                    end else begin
                                        pend_addr <= val16;
                                    end
                                end
                                `CMD_SET_NETID: begin
                                    if (plen != 8'h03) begin
                                        rp[0] <= `ST_BAD_LEN;
                                    end else if (val16 == `ADDR_ALL) begin
                                        rp[0] <= `ST_BAD_VAL;
                                    end else begin
                                        pend_net_id <= val16;
                                    end
                                end
                                `CMD_SET_CHAN: begin
                                    if (plen != 8'h02) begin
                                        rp[0] <= `ST_BAD_LEN;
                                    end else if (pay[1] < `CHAN_MIN ||
                                                 pay[1] > `CHAN_MAX) begin
                                        rp[0] <= `ST_BAD_VAL;
                                    end else begin
                                        pend_chan <= pay[1];
                                    end
                                end
                                `CMD_SET_BAUD: begin
                                    if (plen != 8'h02) begin
                                        rp[0] <= `ST_BAD_LEN;
                                    end else if (!set_known) begin
                                        rp[0] <= `ST_BAD_VAL;
                                    end else begin
                                        pend_baud <= pay[1];
                                    end
                                end
                                `CMD_RESTART: begin
                                    if (plen != 8'h01) begin
                                        rp[0] <= `ST_BAD_LEN;
                                    end else begin
                                        // Apply staged values, no reply
                                        address_out   <= pend_addr;
                                        net_id_out    <= pend_net_id;
                                        channel_out   <= pend_chan;
                                        baud_code_out <= pend_baud;
                                        restart_out   <= 1'b1;
                                        nv_write_out  <= 1'b1;
                                        state         <= S_IDLE;
                                        rx_ready_out  <= 1'b1;
                                    end
                                end
                                default: rp[0] <= `ST_BAD_CMD;
                            endcase
                        end
                    end
                    S_SEND: begin
                        if (!tx_valid_out || tx_ready_in) begin
                            if (tx_idx > tx_end) begin
                                tx_valid_out <= 1'b0;
                                state        <= S_IDLE;
                                rx_ready_out <= 1'b1;
                            end else begin
                                tx_data_out  <= cur_byte;
                                tx_valid_out <= 1'b1;
                                tx_idx       <= tx_idx + 4'h1;
                            end
                        end
                    end
                    default: begin
                        state        <= S_IDLE;
                        rx_ready_out <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // cfg_port_interp

//--- design/cfg_port_consts.vh
// Constants for the configuration port command interpreter
`ifndef CFG_PORT_CONSTS_VH
`define CFG_PORT_CONSTS_VH

// ==========================================================
// Framing
`define FRM_START      8'hFE
`define FRM_END        8'hFF
`define FRM_HDR_LEN    8'h04
`define FRM_HDR_LAST   8'h03
`define PAY_MAX        8'h03
`define LOCAL_ADDR     16'h0000
`define LOCAL_ADDR_LO  8'h00
`define LOCAL_ADDR_HI  8'h00

// ==========================================================
// Ports
`define PORT_HOST      8'h90
`define PORT_CFG       8'h21
`define PORT_ERR       8'h22
`define PORT_LQ        8'h23
`define PORT_SRC_MIN   8'h80

// ==========================================================
// Commands and reply codes
`define CMD_RD_ADDR    8'h01
`define CMD_RD_NETID   8'h02
`define CMD_RD_CHAN    8'h03
`define CMD_RD_BAUD    8'h04
`define CMD_RESTART    8'h10
`define CMD_SET_ADDR   8'h11
`define CMD_SET_NETID  8'h12
`define CMD_SET_CHAN   8'h13
`define CMD_SET_BAUD   8'h14
`define RPL_ADDR       8'h21
`define RPL_NETID      8'h22
`define RPL_CHAN       8'h23
`define RPL_BAUD       8'h24
`define ST_OK          8'h00
`define ST_REMOTE      8'hF0
`define ST_BAD_CMD     8'hF8
`define ST_BAD_LEN     8'hF9
`define ST_BAD_VAL     8'hFA
`define ERR_BAD_PORT   8'hE0

// ==========================================================
// Legal values
`define ADDR_ALL       16'hFFFF
`define CHAN_MIN       8'h0B
`define CHAN_MAX       8'h1A

// ==========================================================
// Baud codes and rates
`define CLK_HZ         40000000
`define BAUD_CODE_MAX  8'h0C
`define BAUD_CODE_DFLT 8'h08
`define BAUD_R0        2400
`define BAUD_R1        4800
`define BAUD_R2        9600
`define BAUD_R3        14400
`define BAUD_R4        19200
`define BAUD_R5        28800
`define BAUD_R6        38400
`define BAUD_R7        57600
`define BAUD_R8        115200
`define BAUD_R9        230400
`define BAUD_RA        125000
`define BAUD_RB        250000
`define BAUD_RC        500000

`endif

//--- design/baud_code_map.v
// Baud code to clock divisor lookup
`timescale 1ns/1ps
`include "cfg_port_consts.vh"

module baud_code_map (
    input  wire [7:0]  code_in,   // Baud code
    output reg  [15:0] div_out,   // Clocks per bit
    output reg         known_out  // Code is defined
);

    reg [31:0] rate;
    reg [31:0] quot;

    // ======================================================
    // Code to rate, rate to divisor
    always @* begin
        rate      = `BAUD_R8;
        known_out = 1'b1;
        case (code_in)
            8'h00:   rate = `BAUD_R0;
            8'h01:   rate = `BAUD_R1;
            8'h02:   rate = `BAUD_R2;
            8'h03:   rate = `BAUD_R3;
            8'h04:   rate = `BAUD_R4;
            8'h05:   rate = `BAUD_R5;
            8'h06:   rate = `BAUD_R6;
            8'h07:   rate = `BAUD_R7;
            8'h08:   rate = `BAUD_R8;
            8'h09:   rate = `BAUD_R9;
            8'h0A:   rate = `BAUD_RA;
            8'h0B:   rate = `BAUD_RB;
            8'h0C:   rate = `BAUD_RC;
            default: known_out = 1'b0;
        endcase
        quot    = `CLK_HZ / rate;
        div_out = quot[15:0]; // Slowest rate still fits 16 bits
    end

endmodule // baud_code_map

//--- sim/cfg_port_chk.sv
// Assertion checker for the configuration port interpreter
`timescale 1ns/1ps
module cfg_port_chk (
    input wire        mclk_in,                 // Clock
    input wire        rst_b_in,                // Reset, active low
    input wire        rx_ready_out,            // Receive ready
    input wire [7:0]  tx_data_out,             // Send byte
    input wire        tx_valid_out,            // Send valid
    input wire        tx_ready_in,             // Send taken
    input wire        baud_default_strap_b_in, // Rate strap
    input wire        nv_write_out,            // Store pulse
    input wire [7:0]  channel_out,             // Applied channel
    input wire [15:0] baud_div_out,            // Divisor
    input wire        restart_out,             // Restart pulse
    input wire        lq_req_out               // Link test pulse
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // ==========================================
    // Pulses, handshakes and settings
    restart_once_a: assert property (restart_out |=> !restart_out)
        else $error("restart pulse too long");
    restart_store_a: assert property (restart_out |-> nv_write_out)
        else $error("restart without store pulse");
    applied_hold_a: assert property ($changed(channel_out) |->
        restart_out || $past(restart_out) || !$past(rst_b_in, 2))
        else $error("channel applied without restart");
    tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
        tx_valid_out && $stable(tx_data_out))
        else $error("send byte dropped");
    frame_start_a: assert property ($rose(tx_valid_out) |-> tx_data_out == 8'hFE)
        else $error("reply not opened by start byte");
    no_rx_tx_a: assert property (tx_valid_out |-> !rx_ready_out)
        else $error("receive open during reply");
    strap_rate_a: assert property (!baud_default_strap_b_in [*3] |->
        baud_div_out == 16'h015B)
        else $error("strap rate not forced");
    lq_once_a: assert property (lq_req_out |=> !lq_req_out)
        else $error("link test pulse too long");
    cover property (restart_out);
    cover property (lq_req_out);
    cover property (tx_valid_out && !tx_ready_in);
endmodule // cfg_port_chk
bind cfg_port_interp cfg_port_chk chk (.*);

//--- sim/host_link_model.sv
// Host side of the byte link: sends queued bytes, collects replies
`timescale 1ns/1ps
module host_link_model (
    input  wire logic       mclk_in,      // Clock
    input  wire logic       stall_in,     // Slow take of reply bytes
    input  wire logic       rx_ready_in,  // Device takes byte
    output logic      [7:0] rx_data_out,  // Byte to device
    output logic            rx_valid_out, // Byte offered
    input  wire logic [7:0] tx_data_in,   // Reply byte
    input  wire logic       tx_valid_in,  // Reply byte valid
    output logic            tx_ready_out  // Reply byte taken
);
    logic [7:0] txq[$];
    logic [7:0] got[$];
    initial begin
        rx_valid_out = 1'b0;
        rx_data_out = 8'h00;
        tx_ready_out = 1'b0;
    end
    // Take at the edge, change a step later; idle data never repeats
    always @(posedge mclk_in) begin
        if (tx_valid_in && tx_ready_out) got.push_back(tx_data_in);
        if (rx_valid_out && rx_ready_in) void'(txq.pop_front());
        #1;
        rx_valid_out = (txq.size() != 0);
        rx_data_out = rx_valid_out ? txq[0] : ~rx_data_out;
        tx_ready_out = stall_in ? ~tx_ready_out : 1'b1;
    end
endmodule // host_link_model

//--- sim/uart_config_port_interpreter_tb.sv
// Self-checking bench for the configuration port interpreter
`timescale 1ns/1ps
module uart_config_port_interpreter_tb;
    typedef logic [7:0] bq_t[$];
    logic mclk_in = 0, rst_b_in = 0, rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
    logic baud_default_strap_b_in = 1, nv_write_out, restart_out, lq_req_out, stall = 0;
    logic [7:0] rx_data_in, tx_data_out, channel_out, baud_code_out;
    logic [15:0] address_out, net_id_out, baud_div_out, lq_target_out, lq_seen = 0;
    logic [15:0] nv_address_in = 16'h000F, nv_net_id_in = 16'h1988;
    logic [7:0] nv_channel_in = 8'h0F, nv_baud_in = 8'h08;
    int err_total = 0, compares = 0, rs_cnt = 0;
    cfg_port_interp dut (.*);
    host_link_model host (.mclk_in(mclk_in), .stall_in(stall), .rx_ready_in(rx_ready_out),
        .rx_data_out(rx_data_in), .rx_valid_out(rx_valid_in), .tx_data_in(tx_data_out),
        .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in));
    initial forever #12.5 mclk_in = ~mclk_in;
    // Catch one-cycle pulses
    always @(posedge mclk_in) begin
        if (lq_req_out) lq_seen <= lq_target_out;
        if (restart_out) rs_cnt <= rs_cnt + 1;
    end
    // ==========================================
    // Shared helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic bq_t frm(input logic [7:0] s, d, input bq_t p, input logic [7:0] a = 0);
        return {8'hFE, 8'(p.size() + 4), s, d, a, 8'h00, p, 8'hFF};
    endfunction
    function automatic bq_t hq(input bq_t p); return frm(8'h90, 8'h21, p); endfunction
    function automatic bq_t rp(input bq_t p); return frm(8'h21, 8'h90, p); endfunction
    task automatic exch(input bq_t s, input bq_t e);
        int n;
        host.got.delete();
        foreach (s[i]) host.txq.push_back(s[i]);
        for (n = 0; n < 200 && (host.txq.size() || host.got.size() < e.size()); n++)
            @(posedge mclk_in);
        repeat (6) @(posedge mclk_in);
        chk(host.got.size(), e.size());
        foreach (e[i]) chk(host.got[i], e[i]);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reads;
        exch(hq('{8'h01}), rp('{8'h21, 8'h0F, 8'h00}));
        exch(hq('{8'h02}), rp('{8'h22, 8'h88, 8'h19}));
        exch(hq('{8'h04}), rp('{8'h24, 8'h08}));
        $display("reads done");
    endtask
    task automatic t_sets;
        stall = 1;
        exch(hq('{8'h13, 8'h12}), rp('{8'h00}));
        exch(hq('{8'h03}), rp('{8'h23, 8'h12}));
        exch(hq('{8'h14, 8'h0C}), rp('{8'h00}));
        exch(hq('{8'h14, 8'h02}), rp('{8'h00}));
        exch(hq('{8'h04}), rp('{8'h24, 8'h02}));
        chk(channel_out, 8'h0F);
        stall = 0;
        $display("sets done");
    endtask
    task automatic t_errs;
        exch(hq('{8'h13, 8'h0A}), rp('{8'hFA}));
        exch(hq('{8'h13, 8'h1B}), rp('{8'hFA}));
        exch(hq('{8'h11, 8'h00, 8'h00}), rp('{8'hFA}));
        exch(hq('{8'h11, 8'hFF, 8'hFF}), rp('{8'hFA}));
        exch(hq('{8'h12, 8'hFF, 8'hFF}), rp('{8'hFA}));
        exch(hq('{8'h14, 8'h0D}), rp('{8'hFA}));
        exch(hq('{8'h05}), rp('{8'hF8}));
        exch(hq('{8'h13}), rp('{8'hF9}));
        exch(frm(8'h90, 8'h21, '{8'h03}, 8'h01), rp('{8'hF0}));
        exch(frm(8'h10, 8'h21, '{8'h01}), frm(8'h22, 8'h10, '{8'hE0, 8'h10}));
        exch(frm(8'h90, 8'h44, '{8'h01}), frm(8'h22, 8'h90, '{8'hE0, 8'h44}));
        exch(frm(8'h90, 8'h22, '{8'h01}), frm(8'h22, 8'h90, '{8'hE0, 8'h22}));
        $display("errors done");
    endtask
    task automatic t_restart;
        exch(hq('{8'h10}), '{});
        chk(rs_cnt, 1);
        chk(channel_out, 8'h12);
        chk(address_out, 16'h000F);
        chk(net_id_out, 16'h1988);
        chk(baud_code_out, 8'h02);
        chk(baud_div_out, 16'h1046);
        exch(frm(8'h90, 8'h23, '{8'h02, 8'h00}), '{});
        chk(lq_seen, 16'h0002);
        @(posedge mclk_in) #1 baud_default_strap_b_in = 0;
        repeat (4) @(posedge mclk_in);
        chk(baud_div_out, 16'h015B);
        #1 baud_default_strap_b_in = 1;
        $display("restart done");
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk_in);
        #1 rst_b_in = 1;
        repeat (2) @(posedge mclk_in);
        t_reads();
        t_sets();
        t_errs();
        t_restart();
        results();
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        err_total++;
        results();
    end
endmodule // uart_config_port_interpreter_tb
